// [fsd_fan_drive.sv]
// Single-phase fan drive control: speed, commutation, protection
`timescale 1ns/1ns
module fsd_fan_drive
    import fsd_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = 32'(RESTART_CYCLES_DEF),
    parameter int unsigned LOCK_CYCLES    = 32'(LOCK_CYCLES_DEF)
)(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              speed_cmd,
    input  wire logic              hall_compare,
    input  wire logic [DUTY_W-1:0] min_speed_setting,
    input  wire logic              overcurrent_protect,
    input  wire logic              thermal_shutdown,
    input  wire logic              undervoltage_lockout,
    output logic                   coil_drive_a_high,
    output logic                   coil_drive_a_low,
    output logic                   coil_drive_b_high,
    output logic                   coil_drive_b_low,
    output logic                   rotation_pulse_out,
    output logic                   lock_active
);
    logic              rst;
    logic [1:0]        hall_sync;
    logic [1:0]        cmd_sync;
    logic              hall_s;
    logic              cmd_s;
    logic              hall_prev;
    logic              cmd_prev;
    logic              hall_edge;
    logic [DUTY_W:0]   high_cnt;
    logic [DUTY_W:0]   gap_cnt;
    logic [DUTY_W-1:0] cmd_duty;
    logic [DUTY_W-1:0] target;
    fsd_state_t        state;
    fsd_state_t        next_state;
    logic [31:0]       lock_cnt;
    logic [31:0]       wait_cnt;
    logic              restart;
    logic              pwm_on;
    logic [DUTY_W-1:0] applied;
    logic              drive_ok;

    assign rst = reset | undervoltage_lockout;

    // Two-stage synchronisers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hall_sync <= 2'h0;
            cmd_sync  <= 2'h0;
        end else begin
            hall_sync <= {hall_sync[0], hall_compare};
            cmd_sync  <= {cmd_sync[0], speed_cmd};
        end
    end
    assign hall_s = hall_sync[1];
    assign cmd_s  = cmd_sync[1];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hall_prev <= 1'b0;
            cmd_prev  <= 1'b0;
        end else begin
            hall_prev <= hall_s;
            cmd_prev  <= cmd_s;
        end
    end
    assign hall_edge = hall_s ^ hall_prev;

    // Command duty: high time counted between rising edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            high_cnt <= 11'h000;
            gap_cnt  <= 11'h000;
            cmd_duty <= DUTY_ZERO;
        end else if (cmd_s && !cmd_prev) begin
            cmd_duty <= (high_cnt >= {1'b0, DUTY_FULL}) ? DUTY_FULL
                      : high_cnt[DUTY_W-1:0];
            high_cnt <= 11'h001;
            gap_cnt  <= 11'h000;
        end else if (gap_cnt >= CMD_TIMEOUT) begin
            cmd_duty <= cmd_s ? DUTY_FULL : DUTY_ZERO;
            high_cnt <= 11'h000;
        end else begin
            gap_cnt <= gap_cnt + 11'h001;
            if (cmd_s && high_cnt < CMD_TIMEOUT) begin
                high_cnt <= high_cnt + 11'h001;
            end
        end
    end

    // Floor at minimum duty, otherwise track command
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            target <= DUTY_ZERO;
        end else if (cmd_duty >= min_speed_setting) begin
            target <= cmd_duty;
        end else begin
            target <= min_speed_setting;
        end
    end

    // Protection state
    always_comb begin
        next_state = state;
        case (state)
            FSD_RUN: begin
                if (thermal_shutdown) begin
                    next_state = FSD_TEMP_OFF;
                end else if (overcurrent_protect) begin
                    next_state = FSD_OC_OFF;
                end else if (lock_cnt >= LOCK_CYCLES - 1 && !hall_edge) begin
                    next_state = FSD_LOCK_OFF;
                end
            end
            FSD_LOCK_OFF, FSD_OC_OFF: begin
                if (thermal_shutdown) begin
                    next_state = FSD_TEMP_OFF;
                end else if (wait_cnt >= RESTART_CYCLES - 1) begin
                    next_state = FSD_RUN;
                end
            end
            FSD_TEMP_OFF: begin
                if (!thermal_shutdown) begin
                    next_state = FSD_RUN;
                end
            end
            default: next_state = FSD_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= FSD_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || state != FSD_RUN || hall_edge) begin
            lock_cnt <= 32'h0000_0000;
        end else begin
            lock_cnt <= lock_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || state == FSD_RUN || state == FSD_TEMP_OFF) begin
            wait_cnt <= 32'h0000_0000;
        end else begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
        end
    end

    // Lock flag holds from detection until rotation resumes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lock_active <= 1'b0;
        end else if (next_state == FSD_LOCK_OFF) begin
            lock_active <= 1'b1;
        end else if (state == FSD_RUN && hall_edge) begin
            lock_active <= 1'b0;
        end
    end

    // Soft start on every restart and every commutation
    assign restart = hall_edge || state != FSD_RUN;

    fsd_soft_pwm u_soft_pwm (
        .ref_clk (ref_clk),
        .rst     (rst),
        .target  (target),
        .restart (restart),
        .pwm_on  (pwm_on),
        .applied (applied)
    );

    assign drive_ok = state == FSD_RUN && !overcurrent_protect
                   && !thermal_shutdown;

    always_ff @(posedge ref_clk) begin
        if (rst || !drive_ok) begin
            coil_drive_a_high <= 1'b0;
            coil_drive_a_low  <= 1'b0;
            coil_drive_b_high <= 1'b0;
            coil_drive_b_low  <= 1'b0;
        end else if (hall_s) begin
            coil_drive_a_high <= 1'b0;
            coil_drive_a_low  <= 1'b1;
            coil_drive_b_high <= pwm_on;
            coil_drive_b_low  <= 1'b0;
        end else begin
            coil_drive_a_high <= pwm_on;
            coil_drive_a_low  <= 1'b0;
            coil_drive_b_high <= 1'b0;
            coil_drive_b_low  <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || lock_active) begin
            rotation_pulse_out <= 1'b0;
        end else begin
            rotation_pulse_out <= ~hall_s;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    lock_pulse_low_a: assert property (lock_active |=> !rotation_pulse_out)
        else $error("Rotation pulse high while locked");
    pulse_follows_hall_a: assert property (
        !lock_active && !$past(lock_active) && !$past(rst) |->
        rotation_pulse_out == !$past(hall_s))
        else $error("Rotation pulse does not follow Hall");
    off_state_idle_a: assert property (state != FSD_RUN |=>
        !coil_drive_a_high && !coil_drive_b_high)
        else $error("Drive active outside run state");
    oc_cut_a: assert property (overcurrent_protect |=>
        !coil_drive_a_high && !coil_drive_b_high && !coil_drive_a_low)
        else $error("Drive not cut on overcurrent");
    thermal_cut_a: assert property (thermal_shutdown |=>
        !coil_drive_a_high && !coil_drive_b_high && !coil_drive_b_low)
        else $error("Drive not cut on thermal shutdown");
    retry_delay_a: assert property (
        state == FSD_RUN && !$past(rst) && ($past(state) == FSD_OC_OFF
        || $past(state) == FSD_LOCK_OFF) |->
        $past(wait_cnt) == RESTART_CYCLES - 1)
        else $error("Restart not at four second interval");
    lock_detect_a: assert property (state == FSD_RUN && !hall_edge
        && !thermal_shutdown && !overcurrent_protect
        && lock_cnt == LOCK_CYCLES - 1 |=> state == FSD_LOCK_OFF)
        else $error("Blocked rotor not detected");
    thermal_hold_a: assert property (state == FSD_TEMP_OFF
        && thermal_shutdown |=> state == FSD_TEMP_OFF)
        else $error("Left thermal shutdown too early");
    no_shoot_a: assert property (!(coil_drive_a_high && coil_drive_a_low)
        && !(coil_drive_b_high && coil_drive_b_low)
        && !(coil_drive_a_high && coil_drive_b_high))
        else $error("Illegal coil drive combination");
    polarity_a: assert property (coil_drive_b_high || coil_drive_a_low
        |-> $past(hall_s))
        else $error("Drive polarity wrong for Hall");
    full_cmd_a: assert property (cmd_duty == DUTY_FULL |=> target == DUTY_FULL)
        else $error("Full command not full speed");
    min_floor_a: assert property (cmd_duty < min_speed_setting
        |=> target == $past(min_speed_setting))
        else $error("Minimum speed floor missing");
    sync_hall_a: assert property (hall_s == $past(hall_sync[0]))
        else $error("Hall synchroniser broken");
    undervoltage_lockout_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        undervoltage_lockout |=> !coil_drive_a_high && !coil_drive_a_low
        && !coil_drive_b_high && !coil_drive_b_low && !rotation_pulse_out)
        else $error("Outputs active in undervoltage");
endmodule : fsd_fan_drive

// [fsd_fan_model.sv]
// Host speed command and Hall sensor model
`timescale 1ns/1ns
module fsd_fan_model
    import fsd_pkg::*;
#(
    parameter int HALL_HALF = 1500
)(
    input  wire logic              ref_clk,
    input  wire logic [DUTY_W-1:0] duty,
    input  wire logic              spin,
    output logic                   speed_cmd,
    output logic                   hall_compare
);
    logic [DUTY_W-1:0] phase;
    int                hall_cnt;
    initial begin
        phase = '0;
        hall_cnt = 0;
        speed_cmd = 1'b0;
        hall_compare = 1'b0;
    end
    // Host PWM, one period of PWM_PERIOD clocks
    always @(posedge ref_clk) begin
        phase <= (phase == PWM_PERIOD - 1'b1) ? '0 : phase + 1'b1;
        speed_cmd <= (phase < duty);
    end
    // Hall edges only while the rotor turns
    always @(posedge ref_clk) begin
        if (spin) begin
            hall_cnt <= (hall_cnt == HALL_HALF - 1) ? 0 : hall_cnt + 1;
            if (hall_cnt == HALL_HALF - 1) begin
                hall_compare <= ~hall_compare;
            end
        end
    end
endmodule : fsd_fan_model

// [fsd_pkg.sv]
// Constants for the single-phase fan drive control block
// Summary of operation
// - Command held high gives full speed
// - Minimum duty threshold set by min-speed setting
// - Above threshold, speed rises with duty
// - Below threshold, fan holds minimum speed
// - Blocked rotor: outputs off, soft-start retries
// - Locked restart attempts spaced four seconds
// - Overcurrent: drive off, retry after four seconds
// - Undervoltage disables drive, holds logic reset
// - Thermal shutdown turns motor drive off
// - Restart only after thermal hysteresis clears
// - Coil current ramped at each commutation
// - Rotation pulse follows each phase switch
// - Rotation pulse held low while locked
package fsd_pkg;
    localparam longint unsigned CLK_HZ          = 64'd25_000_000;
    localparam longint unsigned PWM_FREQ_HZ     = 64'd25_000;
    localparam longint unsigned RESTART_TIME_MS = 64'd4000;
    localparam longint unsigned LOCK_TIME_MS    = 64'd500;
    localparam longint unsigned MS_PER_S        = 64'd1000;

    localparam int DUTY_W = 10;
    localparam logic [DUTY_W-1:0] PWM_PERIOD =
        DUTY_W'(CLK_HZ / PWM_FREQ_HZ);
    localparam logic [DUTY_W-1:0] DUTY_FULL  = PWM_PERIOD;
    localparam logic [DUTY_W-1:0] DUTY_ZERO  = 10'h000;
    localparam logic [DUTY_W-1:0] RAMP_STEP  = 10'h008;
    localparam logic [DUTY_W:0]   CMD_TIMEOUT = {PWM_PERIOD, 1'b0};

    localparam longint unsigned RESTART_CYCLES_DEF =
        RESTART_TIME_MS * CLK_HZ / MS_PER_S;
    localparam longint unsigned LOCK_CYCLES_DEF =
        LOCK_TIME_MS * CLK_HZ / MS_PER_S;

    typedef enum logic [1:0] {
        FSD_RUN      = 2'b00,
        FSD_LOCK_OFF = 2'b01,
        FSD_OC_OFF   = 2'b10,
        FSD_TEMP_OFF = 2'b11
    } fsd_state_t;
endpackage : fsd_pkg

// [fsd_soft_pwm.sv]
// Drive PWM generator with soft duty ramp
`timescale 1ns/1ns
module fsd_soft_pwm
    import fsd_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [DUTY_W-1:0] target,
    input  wire logic              restart,
    output logic                   pwm_on,
    output logic      [DUTY_W-1:0] applied
);
    logic [DUTY_W-1:0] cnt;
    logic              wrap;

    assign wrap   = (cnt == PWM_PERIOD - 10'h001);
    assign pwm_on = (cnt < applied);

    always_ff @(posedge ref_clk) begin
        if (rst || wrap) begin
            cnt <= DUTY_ZERO;
        end else begin
            cnt <= cnt + 10'h001;
        end
    end

    // Duty restarts from zero and climbs one step per period
    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            applied <= DUTY_ZERO;
        end else if (wrap) begin
            if (applied + RAMP_STEP <= target) begin
                applied <= applied + RAMP_STEP;
            end else if (applied > target + RAMP_STEP) begin
                applied <= applied - RAMP_STEP;
            end else begin
                applied <= target;
            end
        end
    end

    ramp_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        !restart && $past(!restart) |->
        (applied <= $past(applied) + RAMP_STEP) &&
        (applied + RAMP_STEP >= $past(applied)))
        else $error("Drive duty changed by more than one step");
    ramp_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        restart |=> applied == DUTY_ZERO)
        else $error("Duty not cleared at commutation");
endmodule : fsd_soft_pwm

// [test_single_phase_fan_drive_control.sv]
// Testbench for the fan drive control block
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("wrong value %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module test_single_phase_fan_drive_control;
    import fsd_pkg::*;
    localparam int RST_N = 2000;
    localparam int LCK_N = 8000;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic [DUTY_W-1:0] duty = DUTY_ZERO;
    logic [DUTY_W-1:0] min_speed_setting = DUTY_ZERO;
    logic              spin = 1'b0;
    logic              overcurrent_protect = 1'b0;
    logic              thermal_shutdown = 1'b0;
    logic              undervoltage_lockout = 1'b0;
    logic              speed_cmd, hall_compare, rotation_pulse_out;
    logic              a_hi, a_lo, b_hi, b_lo, lock_active;
    int                errors = 0;
    int                total_checks = 0;
    int                cycles = 0;
    fsd_fan_model i_model (.ref_clk(ref_clk), .duty(duty), .spin(spin),
        .speed_cmd(speed_cmd), .hall_compare(hall_compare));
    fsd_fan_drive #(.RESTART_CYCLES(RST_N), .LOCK_CYCLES(LCK_N)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .speed_cmd(speed_cmd),
        .hall_compare(hall_compare), .min_speed_setting(min_speed_setting),
        .overcurrent_protect(overcurrent_protect),
        .thermal_shutdown(thermal_shutdown),
        .undervoltage_lockout(undervoltage_lockout),
        .coil_drive_a_high(a_hi), .coil_drive_a_low(a_lo),
        .coil_drive_b_high(b_hi), .coil_drive_b_low(b_lo),
        .rotation_pulse_out(rotation_pulse_out), .lock_active(lock_active));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic drv();
        return a_hi | a_lo | b_hi | b_lo;
    endfunction : drv
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic count_hi(input int n, output int c);
        c = 0;
        repeat (n) begin
            tick(1);
            c += int'(a_hi | b_hi);
        end
    endtask : count_hi
    // Cycles until the OR of all drives equals lvl, bounded
    task automatic wait_drv(input logic lvl, input int lim, output int n);
        n = 0;
        while (drv() !== lvl && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_drv
    task automatic wait_hall;
        logic h;
        int   n;
        h = hall_compare;
        n = 0;
        while (hall_compare === h && n < 4000) begin
            tick(1);
            n++;
        end
    endtask : wait_hall
    task automatic t_reset;
        tick(10);
        `CHK("drive in reset", 1'b0, drv())
        `CHK("pulse in reset", 1'b0, rotation_pulse_out)
        reset <= 1'b0;
    endtask : t_reset
    task automatic t_speed;
        int c;
        spin <= 1'b1;
        tick(4000);
        count_hi(3000, c);
        `CHK("zero cmd drive", 1'b1, c == 0)
        min_speed_setting <= 10'h064;
        tick(2000);
        count_hi(3000, c);
        `CHK("min speed drive", 1'b1, c > 0)
        min_speed_setting <= DUTY_ZERO;
        duty <= DUTY_FULL;
        tick(3000);
        count_hi(3000, c);
        `CHK("full cmd drive", 1'b1, c > 0)
    endtask : t_speed
    task automatic t_switch;
        int   c;
        logic p;
        wait_hall();
        count_hi(1000, c);
        `CHK("soft switch", 1'b1, c <= 3 * RAMP_STEP)
        wait_hall();
        p = rotation_pulse_out;
        tick(1);
        `CHK("pulse unsynced", p, rotation_pulse_out)
        tick(3);
        `CHK("pulse level", ~hall_compare, rotation_pulse_out)
        `CHK("a low side", hall_compare, a_lo)
        `CHK("b low side", ~hall_compare, b_lo)
        `CHK("a high off", 1'b0, a_hi & hall_compare)
    endtask : t_switch
    task automatic t_lock;
        int n;
        spin <= 1'b0;
        n = 0;
        while (lock_active !== 1'b1 && n < LCK_N + 100) begin
            tick(1);
            n++;
        end
        `CHK("lock time", 1'b1, n > LCK_N - 1600 && n < LCK_N + 8)
        tick(2);
        `CHK("lock drive", 1'b0, drv())
        wait_drv(1'b1, RST_N + 100, n);
        `CHK("retry gap", 1'b1, n > RST_N - 10 && n < RST_N + 6)
        `CHK("lock pulse", 1'b0, rotation_pulse_out)
        wait_drv(1'b0, LCK_N + 100, n);
        `CHK("relock", 1'b1, n > LCK_N - 8 && n < LCK_N + 8)
        spin <= 1'b1;
        n = 0;
        while (lock_active !== 1'b0 && n < RST_N + 1800) begin
            tick(1);
            n++;
        end
        `CHK("lock cleared", 1'b0, lock_active)
    endtask : t_lock
    task automatic t_oc;
        int n;
        tick(100);
        overcurrent_protect <= 1'b1;
        tick(2);
        `CHK("oc drive", 1'b0, drv())
        overcurrent_protect <= 1'b0;
        wait_drv(1'b1, RST_N + 100, n);
        `CHK("oc retry", 1'b1, n > RST_N - 8 && n < RST_N + 6)
    endtask : t_oc
    task automatic t_temp;
        int   n;
        logic any;
        thermal_shutdown <= 1'b1;
        tick(2);
        any = 1'b0;
        repeat (3000) begin
            tick(1);
            any |= drv();
        end
        `CHK("hot drive", 1'b0, any)
        thermal_shutdown <= 1'b0;
        wait_drv(1'b1, 50, n);
        `CHK("cool restart", 1'b1, drv())
    endtask : t_temp
    task automatic t_uv;
        tick(100);
        undervoltage_lockout <= 1'b1;
        tick(2);
        `CHK("uv drive", 1'b0, drv())
        `CHK("uv pulse", 1'b0, rotation_pulse_out)
        `CHK("uv lock", 1'b0, lock_active)
        undervoltage_lockout <= 1'b0;
    endtask : t_uv
    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // Hang guard, well above the planned run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            results();
        end
    end
    initial begin
        t_reset();
        t_speed();
        t_switch();
        t_lock();
        t_oc();
        t_temp();
        t_uv();
        results();
    end
endmodule : test_single_phase_fan_drive_control
